// ===== verilog/oder_regs.sv
// oder_regs: output driver enable register bank for two channels.
// assumes a single-cycle register port, synchronous to clk, that never
// issues read and write together; read data return one cycle later.
//
// How it works
// - channel A enable register, offset 0x66, resets FFFF
// - zero powers driver down, one enables
// - A bits 11..0 gate A sample bits
// - A bit 13 gates A sync pair
// - channel B register, offset 0x67, resets FFFF
// - B bit 13 gates B sync pair
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

module oder_regs #(
  parameter int SAMPLE_W = oder_pkg::SAMPLE_W
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic [SAMPLE_W-1:0] first_channel_sample_bits, // A data
  input wire logic [SAMPLE_W-1:0] second_channel_sample_bits, // B data
  input wire logic sync_a, // channel A sync level
  input wire logic sync_b, // channel B sync level
  output oder_pkg::oder_pins_s pins_a_o, // channel A pin levels
  output oder_pkg::oder_pins_s pins_a_oe, // channel A driver enables
  output oder_pkg::oder_pins_s pins_b_o, // channel B pin levels
  output oder_pkg::oder_pins_s pins_b_oe, // channel B driver enables
  output logic [15:0] cha_en, // channel A enable register
  output logic [15:0] chb_en // channel B enable register
);

  oder_pkg::oder_req_s req;
  logic [15:0] cha_en_r;
  logic [15:0] chb_en_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic unmap_r;
  logic unmap_hit;
  logic unmap_clr;
  logic [15:0] status_w;
  oder_pkg::oder_pins_s word_a;
  oder_pkg::oder_pins_s word_b;

  // count of powered drivers in one enable word
  function automatic logic [4:0] count_on(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // true when an offset names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == oder_pkg::CHA_EN_OFS) || (a == oder_pkg::CHB_EN_OFS) ||
      (a == oder_pkg::STATUS_OFS);
  endfunction

  assign req.wr = reg_wr;
  assign req.rd = reg_rd;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;

  // channel A enable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cha_en_r <= oder_pkg::CHA_EN_RST;
    end else if (req.wr && req.addr == oder_pkg::CHA_EN_OFS) begin
      cha_en_r <= req.wdata;
    end
  end

  // channel B enable register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chb_en_r <= oder_pkg::CHB_EN_RST;
    end else if (req.wr && req.addr == oder_pkg::CHB_EN_OFS) begin
      chb_en_r <= req.wdata;
    end
  end

  // sticky flag for accesses to unmapped offsets; a new hit beats clear
  assign unmap_hit = (req.wr || req.rd) && !is_mapped(req.addr);
  assign unmap_clr = req.wr && req.addr == oder_pkg::STATUS_OFS &&
    req.wdata[oder_pkg::STAT_UNMAP_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unmap_r <= 1'b0;
    end else if (unmap_hit) begin
      unmap_r <= 1'b1;
    end else if (unmap_clr) begin
      unmap_r <= 1'b0;
    end
  end

  // status: live count of powered drivers per channel
  always_comb begin
    status_w = 16'h0000;
    status_w[oder_pkg::STAT_CNT_A_LSB +: oder_pkg::STAT_CNT_W] =
      count_on(cha_en_r);
    status_w[oder_pkg::STAT_CNT_B_LSB +: oder_pkg::STAT_CNT_W] =
      count_on(chb_en_r);
    status_w[oder_pkg::STAT_UNMAP_BIT] = unmap_r;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        oder_pkg::CHA_EN_OFS: rdata_nxt = cha_en_r;
        oder_pkg::CHB_EN_OFS: rdata_nxt = chb_en_r;
        oder_pkg::STATUS_OFS: rdata_nxt = status_w;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign cha_en = cha_en_r;
  assign chb_en = chb_en_r;

  // spare pin pairs carry no data; software is expected to power them
  // down, but the drivers still obey their enable bits
  always_comb begin
    word_a = '0;
    word_a.sample_bits = first_channel_sample_bits;
    word_a.sync_output_pair = sync_a;
  end

  always_comb begin
    word_b = '0;
    word_b.sample_bits = second_channel_sample_bits;
    word_b.sync_output_pair = sync_b;
  end

  // bit n of each register gates pin n of its channel
  oder_out_drv #(
    .WIDTH(16)
  ) u_drv_a (
    .clk(clk),
    .rst_n(rst_n),
    .data(word_a),
    .en(cha_en_r),
    .pin_o(pins_a_o),
    .pin_oe(pins_a_oe)
  );

  oder_out_drv #(
    .WIDTH(16)
  ) u_drv_b (
    .clk(clk),
    .rst_n(rst_n),
    .data(word_b),
    .en(chb_en_r),
    .pin_o(pins_b_o),
    .pin_oe(pins_b_oe)
  );

endmodule

// ===== verilog/oder_pkg.sv
// oder_pkg: offsets, reset values and pin layout of the output driver
// enable register bank; shared by the bank, its monitor, receiver model and testbench.
package oder_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 12;

  // register offsets
  localparam logic [7:0] CHA_EN_OFS = 8'h66;
  localparam logic [7:0] CHB_EN_OFS = 8'h67;
  localparam logic [7:0] STATUS_OFS = 8'h68;

  // reset values
  localparam logic [15:0] CHA_EN_RST = 16'hFFFF;
  localparam logic [15:0] CHB_EN_RST = 16'hFFFF;

  // field positions inside an enable register
  localparam int SAMPLE_LSB = 0;
  localparam int SAMPLE_MSB = 11;
  localparam int SPARE_LO_BIT = 12;
  localparam int SYNC_BIT = 13;
  localparam int SPARE_MID_BIT = 14;
  localparam int SPARE_HI_BIT = 15;

  // field positions inside the status register
  localparam int STAT_CNT_A_LSB = 0;
  localparam int STAT_CNT_B_LSB = 8;
  localparam int STAT_CNT_W = 5;
  localparam int STAT_UNMAP_BIT = 15;

  // one channel's pin group, laid out like its enable register
  typedef struct packed {
    logic spare_hi;
    logic spare_mid;
    logic sync_output_pair;
    logic spare_lo;
    logic [11:0] sample_bits;
  } oder_pins_s;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } oder_req_s;

endpackage

// ===== verilog/oder_out_drv.sv
// oder_out_drv: one channel's bank of differential output drivers.
// assumes data and enables are synchronous to clk.
`timescale 1ns/1ps

module oder_out_drv #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] data, // word from the data path
  input wire logic [WIDTH-1:0] en, // per-driver enable
  output logic [WIDTH-1:0] pin_o, // driven level per pin
  output logic [WIDTH-1:0] pin_oe // high while a driver is powered
);

  // pin levels are data masked by en; pin_oe follows en, both registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= '0;
    end else begin
      pin_o <= data & en;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= en;
    end
  end

endmodule

// ===== verif/oder_regs_monitor.sv
// oder_regs_monitor: port assertions for the enable register bank.
// assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps

module oder_regs_monitor (
  input wire logic clk, rst_n, reg_wr, reg_rd, sync_a,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata, cha_en, chb_en,
  input wire logic [11:0] first_channel_sample_bits,
  input wire oder_pkg::oder_pins_s pins_a_o, pins_a_oe, pins_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_a;
    reg_wr && reg_addr == oder_pkg::CHA_EN_OFS;
  endsequence
  sequence s_wr_b;
    reg_wr && reg_addr == oder_pkg::CHB_EN_OFS;
  endsequence
  a_write_a: assert property (s_wr_a |=> cha_en == $past(reg_wdata))
    else $error("channel A write lost");
  a_read_a: assert property (reg_rd && reg_addr == 8'h66 |=>
    reg_rdata == $past(cha_en)) else $error("channel A read wrong");
  a_pin_oe_a: assert property (s_wr_a |=> ##1
    pins_a_oe == $past(reg_wdata, 2)) else $error("A enables wrong");
  a_pin_oe_b: assert property (s_wr_b |=> ##1
    pins_b_oe == $past(reg_wdata, 2)) else $error("B enables wrong");
  // pins lag their inputs by one edge, so skip the edge after release
  a_sample_a: assert property ($past(rst_n) |->
    pins_a_o.sample_bits ==
    $past(first_channel_sample_bits & cha_en[11:0]))
    else $error("A sample gating wrong");
  a_sync_a: assert property ($past(rst_n) |->
    pins_a_o.sync_output_pair == $past(sync_a && cha_en[13]))
    else $error("A sync gating wrong");
  a_sync_oe_b: assert property ($past(rst_n) |->
    pins_b_oe.sync_output_pair == $past(chb_en[13]))
    else $error("B sync enable wrong");
  a_keep_en: assert property (reg_wr && reg_addr > 8'h67 |=>
    $stable(cha_en) && $stable(chb_en)) else $error("enables disturbed");
endmodule

bind oder_regs oder_regs_monitor mon (.*);

// ===== verif/oder_rx_model.sv
// oder_rx_model: receiver at the far end of one channel's pin group.
// assumes a powered-down pair reads as 0 at the terminated input.
`timescale 1ns/1ps

module oder_rx_model (
  input wire oder_pkg::oder_pins_s pin_o, // pin levels
  input wire oder_pkg::oder_pins_s pin_oe, // driver enables
  output logic [15:0] seen // levels the receiver sees
);
  assign seen = pin_o & pin_oe;
endmodule

// ===== verif/testbench.sv
// testbench: register port and data stimulus for oder_regs.
// assumes the one-cycle write and read latencies of the bank.
`timescale 1ns/1ps

module testbench;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, sa = 1, sb = 1;
  logic [7:0] addr = '0;
  logic [15:0] wdata = '0, rdata, cha, chb, seen_a, seen_b;
  logic [11:0] da = 12'hA5C, db = 12'h3F1;
  oder_pkg::oder_pins_s pao, paoe, pbo, pboe;
  int n_errors = 0, cmp_count = 0;
  oder_regs uut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .first_channel_sample_bits(da), .second_channel_sample_bits(db),
    .sync_a(sa), .sync_b(sb), .pins_a_o(pao), .pins_a_oe(paoe),
    .pins_b_o(pbo), .pins_b_oe(pboe), .cha_en(cha), .chb_en(chb));
  oder_rx_model rx_a (.pin_o(pao), .pin_oe(paoe), .seen(seen_a));
  oder_rx_model rx_b (.pin_o(pbo), .pin_oe(pboe), .seen(seen_b));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask
  task automatic t_reset();
    rd_chk(8'h66, 16'hFFFF);
    rd_chk(8'h67, 16'hFFFF);
    chk(seen_a, {3'b001, 1'b0, da});
  endtask
  task automatic t_gate();
    wr_reg(8'h66, 16'h2C3A);
    wr_reg(8'h67, 16'h0FFF);
    @(posedge clk);
    #1 chk(seen_a, {4'h2, da & 12'hC3A});
    chk(paoe, 16'h2C3A);
    chk(seen_b, {4'h0, db});
    chk(pboe, 16'h0FFF);
  endtask
  task automatic t_other();
    wr_reg(8'h70, 16'h0000);
    rd_chk(8'h66, 16'h2C3A);
    rd_chk(8'h67, 16'h0FFF);
    rd_chk(8'h70, 16'h0000);
    rd_chk(8'h68, 16'h8C07);
    wr_reg(8'h68, 16'h8000);
    rd_chk(8'h68, 16'h0C07);
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_gate();
    t_other();
    give_verdict();
  end
endmodule
